// file: hw/rtcf_top.sv
// Overview of operation
// - Master request is set when any event flag and its enable are both one.
// - Interrupt pin is pulled low while the master request reads one.
// - Reading the flag register clears the flags it returned; reset pin low clears all flags.
// - Periodic flag sets on an edge of the selected divider tap.
// - Periodic flag sets regardless of its enable; enable only gates the request.
// - Alarm flag sets when current time matches the alarm time.
// - Update flag sets at the end of every update cycle.
// - Low four bits of the flag register read zero, writes ignored.
// - Validity bit ignores writes and reads one while backup source is good.
// - Validity bit reads zero once the backup source is exhausted.
// - Low seven bits of the validity register read zero, writes ignored.
// - Interrupt pin released within 2 us after a flag read ends.
// - Interrupt pin released within 2 us after reset pin goes low.
// - Oscillator runs within 1 s of the run pattern in divider control.
// - Update enable clears when set mode goes high or reset pin low.
// - Alarm byte with both top bits one matches any time value.
// - One update cycle per second, whatever the set mode.
// - Rate code picks one of thirteen divider taps or none.
`timescale 1ns/1ps
module rtcf_top
	import rtcf_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// host bus pins
	input  wire logic [5:0] addr,
	input  wire logic       rd_n,
	input  wire logic       rtc_sel_n,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	// interrupt pin, open drain
	output logic            irq_out,
	output logic            irq_oe,
	// reset and backup pins
	input  wire logic       reset_n,
	input  wire logic       backup_good,
	// control from the mode register
	input  wire logic [2:0] divider_control_field,
	input  wire logic [3:0] rate_select_field,
	input  wire logic       set_mode,
	input  wire logic       enable_wr,
	input  wire logic [2:0] enable_wdata,
	// oscillator tick
	input  wire logic       osc_tick,
	// time and alarm bytes
	input  wire logic [7:0] cur_sec,
	input  wire logic [7:0] cur_min,
	input  wire logic [7:0] cur_hour,
	input  wire logic [7:0] alm_sec,
	input  wire logic [7:0] alm_min,
	input  wire logic [7:0] alm_hour,
	// enable readback
	output logic            periodic_irq_enable,
	output logic            alarm_irq_enable,
	output logic            update_irq_enable
);
	import rtcf_pkg::*;

	rtcf_evt_if ev ();

	logic [9:0]      pins_s1;
	logic [9:0]      pins_s2;
	logic [9:0]      pins_s3;
	logic [9:0]      pins_f;
	logic [5:0]      addr_f;
	logic            rd_act;
	logic            flags_hit;
	logic            valid_hit;
	logic            hard_clr;
	logic            backup_f;
	rtcf_bus_state_e bus_state;
	logic [2:0]      event_flags;
	logic [2:0]      next_flags;
	logic [2:0]      read_snap;
	logic            read_clear;
	logic            master_request_flag;
	logic            next_master;
	logic [2:0]      enables;
	logic [2:0]      set_events;
	logic            set_mode_q;
	logic [7:0]      status_byte;
	logic [7:0]      valid_byte;
	logic            unused_data;

	// carrier hookup
	assign ev.divider_control_field = divider_control_field;
	assign ev.rate_select_field     = rate_select_field;
	assign ev.osc_tick              = osc_tick;
	assign ev.cur_sec               = cur_sec;
	assign ev.cur_min               = cur_min;
	assign ev.cur_hour              = cur_hour;
	assign ev.alm_sec               = alm_sec;
	assign ev.alm_min               = alm_min;
	assign ev.alm_hour              = alm_hour;

	rtcf_divider u_divider (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ev      (ev.divider)
	);

	rtcf_alarm u_alarm (
		.clk     (clk),
		.sys_rst (sys_rst),
		.ev      (ev.alarm)
	);

	// writes to the status registers have no effect
	assign unused_data = ^data_in;

	// three-stage pin synchroniser, bit counts when stages two and three agree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pins_s1 <= PINS_RST;
			pins_s2 <= PINS_RST;
			pins_s3 <= PINS_RST;
			pins_f  <= PINS_RST;
		end else begin
			pins_s1 <= {backup_good, reset_n, rtc_sel_n, rd_n, addr};
			pins_s2 <= pins_s1;
			pins_s3 <= pins_s2;
			pins_f  <= (pins_s2 & pins_s3) | (pins_f & (pins_s2 | pins_s3));
		end
	end

	assign addr_f   = pins_f[PIN_ADDR_LO +: 6];
	assign rd_act   = !pins_f[PIN_RD_N] && !pins_f[PIN_SEL_N];
	assign hard_clr = !pins_f[PIN_RESET_N];
	assign backup_f = pins_f[PIN_BACKUP];

	// register images
	assign status_byte = {master_request_flag, event_flags, 4'h0};
	assign valid_byte  = {backup_f, 7'h00};

	// read strobe decode
	function automatic logic reg_hit(input logic act, input logic [5:0] a,
		input logic [5:0] target);
		reg_hit = act && (a == target);
	endfunction

	assign flags_hit = reg_hit(rd_act, addr_f, ADDR_FLAGS);
	assign valid_hit = reg_hit(rd_act, addr_f, ADDR_VALID);

	// bus sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_state <= BUS_IDLE;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if (flags_hit) begin
						bus_state <= BUS_READ_F;
					end else if (valid_hit) begin
						bus_state <= BUS_READ_V;
					end
				end
				BUS_READ_F: begin
					if (!rd_act) begin
						bus_state <= BUS_IDLE;
					end
				end
				BUS_READ_V: begin
					if (!rd_act) begin
						bus_state <= BUS_IDLE;
					end
				end
				default: begin
					bus_state <= BUS_IDLE;
				end
			endcase
		end
	end

	// data bus drive, held until the strobe ends
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_oe <= 1'b0;
		end else if (bus_state == BUS_IDLE) begin
			data_oe <= flags_hit || valid_hit;
		end else if (bus_state == BUS_READ_F || bus_state == BUS_READ_V) begin
			data_oe <= rd_act;
		end else begin
			data_oe <= 1'b0;
		end
	end

	// read data, flags frozen, validity refreshed
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_out <= DATA_RST;
		end else if (bus_state == BUS_IDLE && flags_hit) begin
			data_out <= status_byte;
		end else if (bus_state == BUS_IDLE && valid_hit) begin
			data_out <= valid_byte;
		end else if (bus_state == BUS_READ_V) begin
			data_out <= valid_byte;
		end
	end

	// flags captured at read start
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			read_snap <= EVENTS_RST;
		end else if (bus_state == BUS_IDLE && flags_hit) begin
			read_snap <= event_flags;
		end
	end

	// clear strobe when a flag read ends
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			read_clear <= 1'b0;
		end else begin
			read_clear <= (bus_state == BUS_READ_F) && !rd_act;
		end
	end

	// event sources, periodic regardless of its enable
	assign set_events = {ev.periodic_tick, ev.alarm_hit, ev.second_tick};

	// flag update, set beats a read clear
	always_comb begin
		next_flags = event_flags;
		if (read_clear) begin
			next_flags = event_flags & ~read_snap;
		end
		next_flags = next_flags | set_events;
		if (hard_clr) begin
			next_flags = EVENTS_RST;
		end
		next_master = |(next_flags & enables);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			event_flags <= EVENTS_RST;
		end else begin
			event_flags <= next_flags;
		end
	end

	// master request follows flags and enables
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			master_request_flag <= 1'b0;
		end else begin
			master_request_flag <= next_master;
		end
	end

	// set mode edge detect
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			set_mode_q <= 1'b0;
		end else begin
			set_mode_q <= set_mode;
		end
	end

	// interrupt enables
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enables <= ENABLES_RST;
		end else begin
			if (hard_clr) begin
				enables <= ENABLES_RST;
			end else begin
				if (enable_wr) begin
					enables <= enable_wdata;
				end
				if (set_mode && !set_mode_q) begin
					enables[EV_U] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			periodic_irq_enable <= 1'b0;
			alarm_irq_enable    <= 1'b0;
			update_irq_enable   <= 1'b0;
		end else begin
			periodic_irq_enable <= enables[EV_P];
			alarm_irq_enable    <= enables[EV_A];
			update_irq_enable   <= enables[EV_U];
		end
	end

	// open-drain interrupt pin, level always low
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= 1'b0;
		end
	end

	// pin driven while the master request is set
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_oe <= 1'b0;
		end else begin
			irq_oe <= next_master;
		end
	end
endmodule

// file: hw/rtcf_pkg.sv
package rtcf_pkg;
	// bus addresses of the two status registers
	localparam logic [5:0] ADDR_FLAGS = 6'h0C;
	localparam logic [5:0] ADDR_VALID = 6'h0D;

	// status byte field positions
	localparam int MASTER_BIT   = 7;
	localparam int PERIODIC_BIT = 6;
	localparam int ALARM_BIT    = 5;
	localparam int UPDATE_BIT   = 4;
	localparam int VALID_BIT    = 7;

	// event vector index {periodic, alarm, update}
	localparam int EV_P = 2;
	localparam int EV_A = 1;
	localparam int EV_U = 0;

	// reset values
	localparam logic [2:0]  EVENTS_RST  = 3'h0;
	localparam logic [2:0]  ENABLES_RST = 3'h0;
	localparam logic [7:0]  DATA_RST    = 8'h00;
	localparam logic [14:0] DIV_RST     = 15'h0000;
	localparam logic [9:0]  PINS_RST    = 10'h3C0;

	// synchronised pin vector positions
	localparam int PIN_ADDR_LO = 0;
	localparam int PIN_RD_N    = 6;
	localparam int PIN_SEL_N   = 7;
	localparam int PIN_RESET_N = 8;
	localparam int PIN_BACKUP  = 9;

	// divider control patterns
	localparam logic [2:0] DV_RUN      = 3'h2;
	localparam logic [1:0] DV_HOLD_TOP = 2'h3;

	// divider taps
	localparam int DIV_STAGES = 15;
	localparam int SECOND_BIT = 14;
	localparam logic [1:0] ALARM_ANY = 2'h3;

	// timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int IRQ_RELEASE_US = 2;
	localparam int IRQ_RELEASE_CYC = (IRQ_RELEASE_US * 1000) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_READ_F = 2'b01,
		BUS_READ_V = 2'b10
	} rtcf_bus_state_e;
endpackage

// file: hw/rtcf_evt_if.sv
`timescale 1ns/1ps
interface rtcf_evt_if;
	logic [2:0] divider_control_field;
	logic [3:0] rate_select_field;
	logic       osc_tick;
	logic       periodic_tick;
	logic       second_tick;
	logic [7:0] cur_sec;
	logic [7:0] cur_min;
	logic [7:0] cur_hour;
	logic [7:0] alm_sec;
	logic [7:0] alm_min;
	logic [7:0] alm_hour;
	logic       alarm_hit;

	modport core (
		output divider_control_field, rate_select_field, osc_tick,
		output cur_sec, cur_min, cur_hour, alm_sec, alm_min, alm_hour,
		input  periodic_tick, second_tick, alarm_hit
	);
	modport divider (
		input  divider_control_field, rate_select_field, osc_tick,
		output periodic_tick, second_tick
	);
	modport alarm (
		input  second_tick, cur_sec, cur_min, cur_hour, alm_sec, alm_min, alm_hour,
		output alarm_hit
	);
endinterface

// file: hw/rtcf_divider.sv
`timescale 1ns/1ps
module rtcf_divider
	import rtcf_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// event carrier
	rtcf_evt_if.divider ev
);
	logic [14:0] div_cnt;
	logic [14:0] next_div;
	logic        run;
	logic        hold;
	logic [3:0]  tap;

	// divider bit index for a rate code, 15 means no tap
	function automatic logic [3:0] tap_index(input logic [3:0] rs);
		case (rs)
			4'h0: tap_index = 4'hF;
			4'h1: tap_index = 4'h6;
			4'h2: tap_index = 4'h7;
			default: tap_index = rs - 4'h2;
		endcase
	endfunction

	assign run = (ev.divider_control_field == DV_RUN);
	assign hold = (ev.divider_control_field[2:1] == DV_HOLD_TOP);
	assign next_div = div_cnt + 15'h0001;
	assign tap = tap_index(ev.rate_select_field);

	// counting chain
	always_ff @(posedge clk) begin
		if (sys_rst || hold) begin
			div_cnt <= DIV_RST;
		end else if (run && ev.osc_tick) begin
			div_cnt <= next_div;
		end
	end

	// tap edge gives the periodic event
	always_ff @(posedge clk) begin
		if (sys_rst || hold || tap == 4'hF) begin
			ev.periodic_tick <= 1'b0;
		end else begin
			ev.periodic_tick <= run && ev.osc_tick && !div_cnt[tap] && next_div[tap];
		end
	end

	// one update each second
	always_ff @(posedge clk) begin
		if (sys_rst || hold) begin
			ev.second_tick <= 1'b0;
		end else begin
			ev.second_tick <= run && ev.osc_tick && !div_cnt[SECOND_BIT]
				&& next_div[SECOND_BIT];
		end
	end
endmodule

// file: hw/rtcf_alarm.sv
`timescale 1ns/1ps
module rtcf_alarm
	import rtcf_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// event carrier
	rtcf_evt_if.alarm ev
);
	// byte match with don't-care code
	function automatic logic byte_match(input logic [7:0] alm, input logic [7:0] cur);
		byte_match = (alm[7:6] == ALARM_ANY) || (alm == cur);
	endfunction

	// compare at each update
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ev.alarm_hit <= 1'b0;
		end else begin
			ev.alarm_hit <= ev.second_tick
				&& byte_match(ev.alm_sec, ev.cur_sec)
				&& byte_match(ev.alm_min, ev.cur_min)
				&& byte_match(ev.alm_hour, ev.cur_hour);
		end
	end
endmodule

// file: verif/rtcf_chk.sv
`timescale 1ns/1ps
module rtcf_chk
	import rtcf_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// host bus
	input  wire logic [5:0] addr,
	input  wire logic       rd_n,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	// pins and enables
	input  wire logic       irq_oe,
	input  wire logic       reset_n,
	input  wire logic       backup_good,
	input  wire logic       set_mode,
	input  wire logic       periodic_irq_enable,
	input  wire logic       alarm_irq_enable,
	input  wire logic       update_irq_enable
);
	localparam int REL_CYC = 200;

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_master_or_flags: assert property ($rose(data_oe) && addr == ADDR_FLAGS |->
		data_out[7] == ((data_out[6] && periodic_irq_enable) ||
		(data_out[5] && alarm_irq_enable) || (data_out[4] && update_irq_enable)))
		else $error("master flag disagrees with flags and enables");
	a_low_nibble: assert property (data_oe |-> data_out[3:0] == 4'h0)
		else $error("reserved flag bits not zero");
	a_valid_low: assert property (data_oe && addr == ADDR_VALID &&
		$past(addr, 3) == ADDR_VALID |-> data_out[6:0] == 7'h00)
		else $error("reserved validity bits not zero");
	a_valid_bit: assert property (data_oe && addr == ADDR_VALID &&
		$past(addr, 3) == ADDR_VALID && $past(backup_good, 3) == backup_good
		|-> data_out[VALID_BIT] == backup_good)
		else $error("validity bit does not follow backup state");
	a_reset_release: assert property (!reset_n [*8] |-> !irq_oe)
		else $error("interrupt held while reset pin low");
	a_reset_enables: assert property (!reset_n [*8] |->
		!periodic_irq_enable && !alarm_irq_enable && !update_irq_enable)
		else $error("enables survive reset pin");
	a_set_mode_clr: assert property ($rose(set_mode) |-> ##[1:3] !update_irq_enable)
		else $error("update enable not cleared by set mode");
	a_read_release: assert property ($rose(rd_n) && addr == ADDR_FLAGS |->
		##[1:REL_CYC] !irq_oe)
		else $error("interrupt not released after flag read");
endmodule

// file: verif/rtcf_host.sv
`timescale 1ns/1ps
module rtcf_host
	import rtcf_pkg::*;
(
	// clock and device answer
	input  wire logic       clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	// bus pins driven by the host
	output logic      [5:0] addr,
	output logic            rd_n,
	output logic            rtc_sel_n
);
	initial begin
		addr = 6'h00;
		rd_n = 1'b1;
		rtc_sel_n = 1'b1;
	end

	// one read cycle, strobe held until the answer is taken
	task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
		int n;
		n = 0;
		d = 8'hXX;
		ok = 1'b0;
		@(posedge clk);
		addr <= a;
		rtc_sel_n <= 1'b0;
		rd_n <= 1'b0;
		while (!ok && n < 20) begin
			@(posedge clk);
			n++;
			if (data_oe === 1'b1) begin
				ok = 1'b1;
				d = data_out;
			end
		end
		repeat (2) @(posedge clk);
		rd_n <= 1'b1;
		rtc_sel_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
endmodule

// file: verif/tb_rtcf_top.sv
`timescale 1ns/1ps
module tb_rtcf_top;
	import rtcf_pkg::*;
	logic       clk, sys_rst, rd_n, rtc_sel_n, data_oe, irq_out, irq_oe, ok;
	logic       reset_n, backup_good, set_mode, enable_wr, pe, ae, ue;
	logic [5:0] addr;
	logic [7:0] data_out, rv, alm;
	logic [2:0] dv, enable_wdata;
	logic [3:0] rs;
	int         err_total, num_checks;

	rtcf_top rtcf_top_i (.clk(clk), .sys_rst(sys_rst), .addr(addr), .rd_n(rd_n),
		.rtc_sel_n(rtc_sel_n), .data_in(8'h00), .data_out(data_out), .data_oe(data_oe),
		.irq_out(irq_out), .irq_oe(irq_oe), .reset_n(reset_n), .backup_good(backup_good),
		.divider_control_field(dv), .rate_select_field(rs), .set_mode(set_mode),
		.enable_wr(enable_wr), .enable_wdata(enable_wdata), .osc_tick(1'b1),
		.cur_sec(8'h12), .cur_min(8'h34), .cur_hour(8'h05), .alm_sec(alm), .alm_min(alm),
		.alm_hour(alm), .periodic_irq_enable(pe), .alarm_irq_enable(ae),
		.update_irq_enable(ue));
	rtcf_host rtcf_host_i (.clk(clk), .data_out(data_out), .data_oe(data_oe), .addr(addr),
		.rd_n(rd_n), .rtc_sel_n(rtc_sel_n));

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [7:0] e, input string nm);
		rtcf_host_i.rd(a, rv, ok);
		chk(nm, e, rv);
		if (ok !== 1'b1) close_out;
	endtask
	task automatic ena(input logic [2:0] v);
		@(posedge clk);
		enable_wr <= 1'b1;
		enable_wdata <= v;
		@(posedge clk);
		enable_wr <= 1'b0;
	endtask
	task automatic run(input logic [3:0] r, input int c);
		rs <= r;
		dv <= DV_RUN;
		repeat (c) @(posedge clk);
		dv <= 3'h6;
		repeat (4) @(posedge clk);
	endtask
	task automatic wait_irq(input int bound);
		int n;
		n = 0;
		while (irq_oe !== 1'b1 && n < bound) begin
			@(posedge clk);
			n++;
		end
		chk("irq_raised", 8'h01, {7'h00, irq_oe});
		if (irq_oe !== 1'b1) close_out;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		err_total = 0;
		num_checks = 0;
		sys_rst = 1'b1;
		reset_n = 1'b1;
		backup_good = 1'b1;
		set_mode = 1'b0;
		enable_wr = 1'b0;
		enable_wdata = 3'h0;
		dv = 3'h6;
		rs = 4'h0;
		alm = 8'h00;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk);
		rdchk(ADDR_VALID, 8'h80, "valid_good");
		backup_good <= 1'b0;
		rdchk(ADDR_VALID, 8'h00, "valid_lost");
		backup_good <= 1'b1;
		rdchk(ADDR_FLAGS, 8'h00, "flags_idle");
		rtcf_host_i.rd(6'h0E, rv, ok);
		chk("unmapped_oe", 8'h00, {7'h00, ok});
		run(4'h3, 40);
		rdchk(ADDR_FLAGS, 8'h40, "periodic_no_en");
		rdchk(ADDR_FLAGS, 8'h00, "flags_cleared");
		ena(3'h4);
		run(4'h0, 300);
		rdchk(ADDR_FLAGS, 8'h00, "rate_none");
		for (int r = 1; r < 16; r++) begin
			rs <= r[3:0];
			dv <= DV_RUN;
			wait_irq(9000);
			dv <= 3'h6;
			repeat (4) @(posedge clk);
			rdchk(ADDR_FLAGS, 8'hC0, "periodic_irq");
			repeat (10) @(posedge clk);
			chk("irq_released", 8'h00, {7'h00, irq_oe});
		end
		ena(3'h3);
		alm <= 8'hC0;
		rs <= 4'h0;
		dv <= DV_RUN;
		wait_irq(17000);
		repeat (5) @(posedge clk);
		dv <= 3'h6;
		rdchk(ADDR_FLAGS, 8'hB0, "alarm_update");
		set_mode <= 1'b1;
		repeat (4) @(posedge clk);
		chk("uie_cleared", 8'h02, {6'h00, ae, ue});
		set_mode <= 1'b0;
		ena(3'h4);
		run(4'h3, 40);
		chk("irq_pending", 8'h01, {7'h00, irq_oe});
		chk("irq_pin_low", 8'h00, {7'h00, irq_out});
		reset_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk("reset_irq_en", 8'h00, {5'h00, irq_oe, pe, ae});
		rdchk(ADDR_FLAGS, 8'h00, "reset_flags");
		reset_n <= 1'b1;
		close_out;
	end
endmodule

bind rtcf_top rtcf_chk rtcf_chk_i (.clk(clk), .sys_rst(sys_rst), .addr(addr), .rd_n(rd_n),
	.data_out(data_out), .data_oe(data_oe), .irq_oe(irq_oe), .reset_n(reset_n),
	.backup_good(backup_good), .set_mode(set_mode),
	.periodic_irq_enable(periodic_irq_enable), .alarm_irq_enable(alarm_irq_enable),
	.update_irq_enable(update_irq_enable));
